// ==== cgoh_consts.vh ====
`ifndef CGOH_CONSTS_VH
`define CGOH_CONSTS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define CGOH_IDX_GAIN_OFS 6'h2B
`define CGOH_IDX_OFS_COPY 6'h2C
`define CGOH_IDX_PAT_HPF 6'h2D
`define CGOH_IDX_CTRL 6'h3C
`define CGOH_IDX_STATUS 6'h3D

// ==========================================================
// reset values
`define CGOH_RST_REG16 16'h0000
`define CGOH_RST_CTRL 3'h0
`define CGOH_RST_PRBS 23'h7FFFFF

// ==========================================================
// field positions, gain/offset register
`define CGOH_GAIN_HI 15
`define CGOH_GAIN_LO 11
`define CGOH_OFS_HI 9
`define CGOH_OFS_LO 0

// field positions, pattern/filter register
`define CGOH_PRBS9_BIT 15
`define CGOH_PRBS10_BIT 14
`define CGOH_PRBS11_BIT 13
`define CGOH_PRBS12_BIT 12
`define CGOH_PAT9_HI 11
`define CGOH_PAT9_LO 9
`define CGOH_PAT10_HI 8
`define CGOH_PAT10_LO 6
`define CGOH_HPFK_HI 4
`define CGOH_HPFK_LO 1
`define CGOH_HPFON_BIT 0

// field positions, control register
`define CGOH_CTRL_GAIN_BIT 0
`define CGOH_CTRL_SHIFT_BIT 1
`define CGOH_CTRL_PLANE_BIT 2

// ==========================================================
// lane pattern codes
`define CGOH_PAT_NORMAL 3'h0
`define CGOH_PAT_ZEROS 3'h1
`define CGOH_PAT_ONES 3'h2
`define CGOH_PAT_TOGGLE 3'h3

// ==========================================================
// gain table scale: unity is 2^14
`define CGOH_GAIN_FRAC 14

`endif

// ==== cgoh_channel_proc.v ====
`timescale 1ns/10ps
`include "cgoh_consts.vh"

module cgoh_channel_proc #(
  parameter W = 14,
  parameter F = 8,
  parameter AW = 8
) (
  input wire mclk,
  input wire rst,
  input wire [AW-1:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire sampleValid,
  input wire [W-1:0] sample9,
  input wire [W-1:0] sample10,
  input wire [W-1:0] sample11,
  input wire [W-1:0] sample12,
  output reg laneValid,
  output reg [W-1:0] lane9,
  output reg [W-1:0] lane10,
  output reg [W-1:0] lane11,
  output reg [W-1:0] lane12
);

  localparam A = W + F + 3;

  // ==========================================================
  // register state
  reg [15:0] gainOfs_q;
  reg [15:0] ofsCopy_q;
  reg [15:0] patHpf_q;
  reg [2:0] ctrl_q;
  reg [22:0] prbs_q;
  reg toggle_q;
  reg signed [A-1:0] xPrev_q [0:3];
  reg signed [A-1:0] yPrev_q [0:3];

  wire [4:0] chan12GainSteps = gainOfs_q[`CGOH_GAIN_HI:`CGOH_GAIN_LO];
  wire [9:0] chan12SignedShift = gainOfs_q[`CGOH_OFS_HI:`CGOH_OFS_LO];
  wire globalGainApply = ctrl_q[`CGOH_CTRL_GAIN_BIT];
  wire globalShiftApply = ctrl_q[`CGOH_CTRL_SHIFT_BIT];
  wire perLanePatternChoice = ctrl_q[`CGOH_CTRL_PLANE_BIT];
  wire [3:0] groupBFilterK = patHpf_q[`CGOH_HPFK_HI:`CGOH_HPFK_LO];
  wire groupBFilterOn = patHpf_q[`CGOH_HPFON_BIT];
  wire [3:0] lanePrbsOn = {patHpf_q[`CGOH_PRBS12_BIT], patHpf_q[`CGOH_PRBS11_BIT],
                           patHpf_q[`CGOH_PRBS10_BIT], patHpf_q[`CGOH_PRBS9_BIT]};
  wire [2:0] lane9PatternCode = patHpf_q[`CGOH_PAT9_HI:`CGOH_PAT9_LO];
  wire [2:0] lane10PatternCode = patHpf_q[`CGOH_PAT10_HI:`CGOH_PAT10_LO];

  // ==========================================================
  // functions

  // gain in steps of 0.2 dB, unity = 2^14; step 31 reaches about 2.04
  function [16:0] gainFactor;
    input [4:0] n;
    begin
      case (n)
        5'h00: gainFactor = 17'h04000;
        5'h01: gainFactor = 17'h0417E;
        5'h02: gainFactor = 17'h04304;
        5'h03: gainFactor = 17'h04494;
        5'h04: gainFactor = 17'h0462D;
        5'h05: gainFactor = 17'h047CF;
        5'h06: gainFactor = 17'h0497B;
        5'h07: gainFactor = 17'h04B32;
        5'h08: gainFactor = 17'h04CF2;
        5'h09: gainFactor = 17'h04EBD;
        5'h0A: gainFactor = 17'h05092;
        5'h0B: gainFactor = 17'h05273;
        5'h0C: gainFactor = 17'h0545F;
        5'h0D: gainFactor = 17'h05655;
        5'h0E: gainFactor = 17'h05858;
        5'h0F: gainFactor = 17'h05A67;
        5'h10: gainFactor = 17'h05C82;
        5'h11: gainFactor = 17'h05EAA;
        5'h12: gainFactor = 17'h060DF;
        5'h13: gainFactor = 17'h06320;
        5'h14: gainFactor = 17'h0656F;
        5'h15: gainFactor = 17'h067CC;
        5'h16: gainFactor = 17'h06A37;
        5'h17: gainFactor = 17'h06CB0;
        5'h18: gainFactor = 17'h06F38;
        5'h19: gainFactor = 17'h071D0;
        5'h1A: gainFactor = 17'h07476;
        5'h1B: gainFactor = 17'h0772D;
        5'h1C: gainFactor = 17'h079F3;
        5'h1D: gainFactor = 17'h07CCA;
        5'h1E: gainFactor = 17'h07FB2;
        default: gainFactor = 17'h082AC;
      endcase
    end
  endfunction

  // clip a wide signed value into the lane width
  function [W-1:0] saturate;
    input signed [A+17:0] v;
    reg signed [A+17:0] maxV;
    reg signed [A+17:0] minV;
    begin
      maxV = (1 <<< (W - 1)) - 1;
      minV = -(1 <<< (W - 1));
      if (v > maxV) begin
        saturate = maxV[W-1:0];
      end else if (v < minV) begin
        saturate = minV[W-1:0];
      end else begin
        saturate = v[W-1:0];
      end
    end
  endfunction

  // 2^k/(2^k+1) as 1 - 2^-k + 2^-2k; the truncated series costs under 2^-3k, so under 2^-6 at k>=2
  function signed [A-1:0] hpfScale;
    input signed [A-1:0] s;
    input [3:0] k;
    begin
      hpfScale = s - (s >>> k) + (s >>> {k, 1'b0});
    end
  endfunction

  // ==========================================================
  // datapath: filter, channel 12 gain and offset, pattern mux
  reg signed [A-1:0] xIn [0:3];
  reg signed [A-1:0] yNew [0:3];
  reg signed [A+17:0] wide [0:3];
  reg [W-1:0] chanOut [0:3];
  reg [W-1:0] laneOut [0:3];
  reg signed [A+17:0] prod12;
  integer i;
  integer j;

  always @* begin
    prod12 = {(A + 18){1'b0}};
    for (i = 0; i < 4; i = i + 1) begin
      case (i)
        0: xIn[i] = {{3{sample9[W-1]}}, sample9, {F{1'b0}}};
        1: xIn[i] = {{3{sample10[W-1]}}, sample10, {F{1'b0}}};
        2: xIn[i] = {{3{sample11[W-1]}}, sample11, {F{1'b0}}};
        default: xIn[i] = {{3{sample12[W-1]}}, sample12, {F{1'b0}}};
      endcase
      // k only matters on this path, which is taken only while the filter is on
      yNew[i] = hpfScale(xIn[i] - xPrev_q[i] + yPrev_q[i], groupBFilterK);
      // a concatenation is unsigned, so it is re-signed before the arithmetic shift
      if (groupBFilterOn) begin
        wide[i] = $signed({{18{yNew[i][A-1]}}, yNew[i]}) >>> F;
      end else begin
        wide[i] = $signed({{18{xIn[i][A-1]}}, xIn[i]}) >>> F;
      end
    end
    if (globalGainApply) begin
      prod12 = (wide[3] * $signed({1'b0, gainFactor(chan12GainSteps)})) >>> `CGOH_GAIN_FRAC;
      wide[3] = prod12;
    end
    if (globalShiftApply) begin
      // offset counts in output LSBs; the copy register is assumed equal
      wide[3] = wide[3] + {{(A + 8){chan12SignedShift[9]}}, chan12SignedShift};
    end
    for (i = 0; i < 4; i = i + 1) begin
      chanOut[i] = saturate(wide[i]);
      laneOut[i] = chanOut[i];
      if (perLanePatternChoice) begin
        if (lanePrbsOn[i]) begin
          laneOut[i] = prbs_q[W-1:0] ^ i[W-1:0];
        end else if (i < 2) begin
          case ((i == 0) ? lane9PatternCode : lane10PatternCode)
            `CGOH_PAT_ZEROS: laneOut[i] = {W{1'b0}};
            `CGOH_PAT_ONES: laneOut[i] = {W{1'b1}};
            `CGOH_PAT_TOGGLE: laneOut[i] = {W{toggle_q}};
            default: laneOut[i] = chanOut[i];
          endcase
        end
      end
    end
  end

  // ==========================================================
  // sample pipeline: filter state, PRBS, registered lanes
  always @(posedge mclk) begin
    if (rst) begin
      laneValid <= 1'b0;
      lane9 <= {W{1'b0}};
      lane10 <= {W{1'b0}};
      lane11 <= {W{1'b0}};
      lane12 <= {W{1'b0}};
      prbs_q <= `CGOH_RST_PRBS;
      toggle_q <= 1'b0;
      for (j = 0; j < 4; j = j + 1) begin
        xPrev_q[j] <= {A{1'b0}};
        yPrev_q[j] <= {A{1'b0}};
      end
    end else begin
      laneValid <= sampleValid;
      if (sampleValid) begin
        lane9 <= laneOut[0];
        lane10 <= laneOut[1];
        lane11 <= laneOut[2];
        lane12 <= laneOut[3];
        prbs_q <= {prbs_q[21:0], prbs_q[22] ^ prbs_q[17]};
        toggle_q <= ~toggle_q;
        for (j = 0; j < 4; j = j + 1) begin
          xPrev_q[j] <= xIn[j];
          // clear history while bypassed so enabling starts without a jump
          yPrev_q[j] <= groupBFilterOn ? yNew[j] : {A{1'b0}};
        end
      end
    end
  end

  // ==========================================================
  // Avalon-MM slave: one wait cycle, then the access completes
  wire [AW-3:0] regIdx = address[AW-1:2];
  wire busReq = read | write;
  wire busDone = busReq & ~waitrequest;

  function [15:0] mergeBytes;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      mergeBytes = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  always @(posedge mclk) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      gainOfs_q <= `CGOH_RST_REG16;
      ofsCopy_q <= `CGOH_RST_REG16;
      patHpf_q <= `CGOH_RST_REG16;
      ctrl_q <= `CGOH_RST_CTRL;
    end else begin
      waitrequest <= ~(busReq & waitrequest);
      if (busReq & waitrequest) begin
        // read data is loaded as waitrequest drops; unmapped reads return zero
        case (regIdx)
          `CGOH_IDX_GAIN_OFS: readdata <= {16'h0000, gainOfs_q};
          `CGOH_IDX_OFS_COPY: readdata <= {16'h0000, ofsCopy_q};
          `CGOH_IDX_PAT_HPF: readdata <= {16'h0000, patHpf_q};
          `CGOH_IDX_CTRL: readdata <= {29'h00000000, ctrl_q};
          // upper half always reads zero, like every other register word
          `CGOH_IDX_STATUS: readdata <= {{(32 - W){1'b0}}, lane12};
          default: readdata <= 32'h00000000;
        endcase
      end
      // reserved bits inside the 16-bit registers are stored as written; control keeps only bits 2:0; software keeps them zero
      if (busDone & write) begin
        case (regIdx)
          `CGOH_IDX_GAIN_OFS: gainOfs_q <= mergeBytes(gainOfs_q, writedata, byteenable);
          `CGOH_IDX_OFS_COPY: ofsCopy_q <= mergeBytes(ofsCopy_q, writedata, byteenable);
          `CGOH_IDX_PAT_HPF: patHpf_q <= mergeBytes(patHpf_q, writedata, byteenable);
          `CGOH_IDX_CTRL: ctrl_q <= byteenable[0] ? writedata[2:0] : ctrl_q;
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

endmodule

// ==== cgoh_channel_proc_assertions.sv ====
`timescale 1ns/10ps
// ======
// bus handshake and lane timing
module cgoh_checker #(parameter W = 14) (
  input wire mclk,
  input wire rst,
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire sampleValid,
  input wire laneValid,
  input wire [W-1:0] lane9,
  input wire [W-1:0] lane12
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // a slave that stalls past one wait cycle would starve back-to-back masters
  property p_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_one; !waitrequest |=> waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer held");
  property p_up; !waitrequest |-> readdata[31:16] == 16'h0000; endproperty
  a_up: assert property (p_up) else $error("upper read bits set");
  property p_lat; sampleValid |=> laneValid; endproperty
  a_lat: assert property (p_lat) else $error("lane word missing");
  property p_nolat; !sampleValid |=> !laneValid; endproperty
  a_nolat: assert property (p_nolat) else $error("spurious lane word");
  property p_hold; !sampleValid |=> $stable(lane9) && $stable(lane12); endproperty
  a_hold: assert property (p_hold) else $error("lane moved unprompted");
  property p_rst; $fell(rst) |-> waitrequest && !laneValid && lane12 == '0; endproperty
  a_rst: assert property (p_rst) else $error("state not cleared");
  c_rd: cover property (read && !waitrequest);
  c_wr: cover property (write && !waitrequest);
  c_lane: cover property (laneValid);
endmodule
bind cgoh_channel_proc cgoh_checker #(.W(W)) u_chk (.mclk(mclk), .rst(rst), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .sampleValid(sampleValid), .laneValid(laneValid),
  .lane9(lane9), .lane12(lane12));

// ==== cgoh_lane_rx.sv ====
`timescale 1ns/10ps
// ======
// far-side receiver
module cgoh_lane_rx (
  input wire mclk,
  input wire laneValid,
  input wire [13:0] lane9,
  input wire [13:0] lane10,
  input wire [13:0] lane11,
  input wire [13:0] lane12,
  output reg [55:0] rxWord
);
  // no back-pressure exists, so every valid cycle is latched at once
  always @(posedge mclk) begin
    if (laneValid) begin
      rxWord <= {lane9, lane10, lane11, lane12};
    end
  end
endmodule

// ==== cgoh_channel_proc_test.sv ====
`timescale 1ns/10ps
module cgoh_channel_proc_test;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg read = 1'b0;
  reg write = 1'b0;
  reg sampleValid = 1'b0;
  reg [7:0] address = 8'h00;
  reg [31:0] writedata = 32'h0;
  reg [55:0] smp = 56'h0;
  reg [22:0] lfsr = 23'h7FFFFF;
  reg tgl = 1'b0;
  reg [111:0] rows [0:1];
  reg [31:0] rd;
  reg [13:0] px;
  wire waitrequest, laneValid;
  wire [31:0] readdata;
  wire [13:0] lane9, lane10, lane11, lane12;
  wire [55:0] rxWord;
  integer n_mismatch = 0;
  integer n_tests = 0;
  integer i, k;
  longint xp, yp, s;
  // ======
  // clock and both ends
  always #2.5 mclk = ~mclk;
  cgoh_channel_proc dut (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write), .byteenable(4'hF),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .sampleValid(sampleValid),
    .sample9(smp[55:42]), .sample10(smp[41:28]), .sample11(smp[27:14]), .sample12(smp[13:0]),
    .laneValid(laneValid), .lane9(lane9), .lane10(lane10), .lane11(lane11), .lane12(lane12));
  cgoh_lane_rx rx (.mclk(mclk), .laneValid(laneValid), .lane9(lane9), .lane10(lane10), .lane11(lane11),
    .lane12(lane12), .rxWord(rxWord));
  // ======
  // helpers
  task check(input [63:0] seen, input [63:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("mismatches %0d of %0d compares", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // request held until waitrequest is seen low; the bound catches a dead slave
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      read <= ~w;
      write <= w;
      address <= a;
      writedata <= d;
      k = 0;
      @(posedge mclk);
      while (waitrequest !== 1'b0 && k < 40) begin
        @(posedge mclk);
        k = k + 1;
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (k == 40) begin
        n_mismatch = n_mismatch + 1;
        final_report;
      end
    end
  endtask
  // latency is fixed at one cycle, so the far end holds the word two edges on
  task smpl(input [55:0] v, input [55:0] e);
    begin
      @(posedge mclk);
      smp <= v;
      sampleValid <= 1'b1;
      @(posedge mclk);
      sampleValid <= 1'b0;
      lfsr = {lfsr[21:0], lfsr[22] ^ lfsr[17]};
      tgl = ~tgl;
      @(posedge mclk);
      #1;
      check(rxWord, e);
    end
  endtask
  function [13:0] pat(input [1:0] c);
    pat = c == 2'h0 ? 14'h0123 : c == 2'h1 ? 14'h0000 : c == 2'h2 ? 14'h3FFF : {14{tgl}};
  endfunction
  // ======
  // main sequence
  initial begin
    rows[0] = {2{14'h1FFF, 14'h2000, 14'h3FFF, 14'h0001}};
    rows[1] = 112'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      bus(0, 8'hAC + {i[5:0], 2'h0}, 0);
      check(rd, 0);
    end
    bus(0, 8'hF0, 0);
    check(rd, 0);
    // k of 10 with the filter off must leave samples alone
    bus(1, 8'hB4, 32'h00000014);
    bus(0, 8'hB4, 0);
    check(rd, 32'h00000014);
    for (i = 0; i < 2; i = i + 1)
      smpl(rows[i][111:56], rows[i][55:0]);
    // step of 1000 through the k = 2 high-pass
    bus(1, 8'hB4, 32'h00000005);
    xp = 0;
    yp = 0;
    for (i = 0; i < 4; i = i + 1) begin
      s = 256000 - xp + yp;
      yp = s - (s >>> 2) + (s >>> 4);
      xp = 256000;
      px = 14'(yp >>> 8);
      smpl({4{14'h03E8}}, {4{px}});
    end
    // channel 12 only: gain of 30 steps, then offset of -5
    bus(1, 8'hB4, 0);
    bus(1, 8'hAC, 32'h0000F000);
    bus(1, 8'hF0, 32'h1);
    px = 14'((1000 * $rtoi(16384.0 * 10.0 ** 0.3 + 0.5)) >>> 14);
    smpl({4{14'h03E8}}, {{3{14'h03E8}}, px});
    bus(1, 8'hAC, 32'h000003FB);
    bus(1, 8'hB0, 32'h000003FB);
    bus(1, 8'hF0, 32'h2);
    smpl({4{14'h03E8}}, {{3{14'h03E8}}, 14'h03E3});
    // every lane code on lanes 9 and 10, then PRBS on all four
    bus(1, 8'hF0, 32'h4);
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, 8'hB4, {20'h0, i[2:0], i[2:0], 6'h00});
      smpl({4{14'h0123}}, {pat(i[1:0]), pat(i[1:0]), {2{14'h0123}}});
    end
    bus(1, 8'hB4, 32'h0000F000);
    px = lfsr[13:0] ^ 14'h0003;
    smpl(56'h0, {lfsr[13:0], lfsr[13:0] ^ 14'h0001, lfsr[13:0] ^ 14'h0002, px});
    bus(0, 8'hF4, 0);
    check(rd, {18'h00000, px});
    // mid-run reset must restore bypass and clear every register
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      bus(0, 8'hAC + {i[5:0], 2'h0}, 0);
      check(rd, 0);
    end
    bus(0, 8'hF0, 0);
    check(rd, 0);
    smpl(rows[0][111:56], rows[0][55:0]);
    final_report;
  end
endmodule
